/* File: pkg/tmrc_pkg.sv */
// Functional notes
// - reload buffer on: reload value loads from shadow at update events; else direct.
// - one-shot: hardware clears run bit and stops counting at next update event.
// - source select 0: software, overflow, slave update all flag; 1: overflow only.
// - update inhibit keeps buffered values; software or slave reset still reinitialises.
// - software sets run bit in clock/pause modes; event mode sets it by hardware.
// - outputs disabled: complementary output drives its idle level bit.
// - outputs disabled: channel 0 output drives idle level after dead-time.
// - idle-level bits writable only while lock level is 00.
// - master mode 000: trigger out pulses on software update or slave reset, delayed.
// - master mode 001: trigger out follows internal counter enable.
// - master mode 010 carries update event; 011 pulses on channel 0 match.
// - master modes 100..111 carry compare reference of channels 0..3.
// - channel dma request on its event if source bit 0, update if 1.
// - commutation update on software request, or also on trigger rising edge.
// - commutation buffering shadows the main and complementary enable bits until commutation.
// - master-slave sync passes trigger input as start event to trigger out.
// - trigger select: 000/001 internal, 100 edge flag, 101/110 filtered; others reserved.
// - slave mode 000: counts on kernel clock while run bit set; 001..011 reserved.
// - mode 100 restarts on rising trigger; mode 101 counts while trigger high.
// - mode 110 starts on rising trigger, never stopped; 111 counts rising edges.
// - dma requests and interrupts issue only when their enable bit is set.
package tmrc_pkg;
  localparam logic [4:0] TMRC_OFS_CTRL = 5'h00;
  localparam logic [4:0] TMRC_OFS_OUT = 5'h04;
  localparam logic [4:0] TMRC_OFS_SLAVE = 5'h08;
  localparam logic [4:0] TMRC_OFS_EN = 5'h0C;
  localparam logic [4:0] TMRC_OFS_FLAGS = 5'h10;
  localparam logic [4:0] TMRC_OFS_SWEV = 5'h14;
  localparam logic [4:0] TMRC_OFS_RELOAD = 5'h18;
  localparam logic [4:0] TMRC_OFS_LOCK_LEVEL = 5'h1C;
  localparam logic [15:0] TMRC_RST = 16'h0000;
  // counter_control bits
  localparam int TMRC_B_RUN = 0;
  localparam int TMRC_B_INH = 1;
  localparam int TMRC_B_UPS = 2;
  localparam int TMRC_B_ONE = 3;
  localparam int TMRC_B_ARB = 7;
  localparam logic [15:0] TMRC_CTRL_MASK = 16'h008F;
  // output_ctrl_trigger_out bits
  localparam int TMRC_B_COMMUTATION_BUFFERING = 0;
  localparam int TMRC_B_COMMUTATION_UPDATE_CONTROL = 2;
  localparam int TMRC_B_DMA_SOURCE_SELECT = 3;
  localparam int TMRC_B_MMLO = 4;
  localparam int TMRC_B_CH0_IDLE_LEVEL = 8;
  localparam int TMRC_B_CH0_COMPL_IDLE_LEVEL = 9;
  localparam int TMRC_B_CH1_IDLE_LEVEL = 10;
  localparam logic [15:0] TMRC_OUT_MASK = 16'h007D;
  localparam logic [15:0] TMRC_ISO_MASK = 16'h0700;
  // slave_mode_config bits
  localparam int TMRC_B_SMLO = 0;
  localparam int TMRC_B_TSLO = 4;
  localparam int TMRC_B_MSM = 7;
  localparam logic [15:0] TMRC_SLV_MASK = 16'h00F7;
  // dma_irq_enables mask and bits
  localparam logic [15:0] TMRC_EN_MASK = 16'h67E7;
  localparam int TMRC_B_UPDATE_IRQ_ENABLE = 0;
  localparam int TMRC_B_CH0_IRQ_ENABLE = 1;
  localparam int TMRC_B_CH1_IRQ_ENABLE = 2;
  localparam int TMRC_B_COMMUTATION_IRQ_ENABLE = 5;
  localparam int TMRC_B_TRIGGER_IRQ_ENABLE = 6;
  localparam int TMRC_B_BREAK_IRQ_ENABLE = 7;
  localparam int TMRC_B_UPDATE_DMA_ENABLE = 8;
  localparam int TMRC_B_CH0_DMA_ENABLE = 9;
  localparam int TMRC_B_CH1_DMA_ENABLE = 10;
  localparam int TMRC_B_COMMUTATION_DMA_ENABLE = 13;
  localparam int TMRC_B_TRIGGER_DMA_ENABLE = 14;
  // event_flags bits, same positions for software event generation
  localparam int TMRC_F_UP = 0;
  localparam int TMRC_F_CH0 = 1;
  localparam int TMRC_F_CH1 = 2;
  localparam int TMRC_F_CMT = 5;
  localparam int TMRC_F_TRG = 6;
  localparam int TMRC_F_BRK = 7;
  localparam logic [15:0] TMRC_FLAG_MASK = 16'h06E7;
  localparam logic [1:0] TMRC_LOCK_OPEN = 2'h0;
  localparam int TMRC_DT_CYCLES = 4;

  typedef enum logic [2:0] {
    TMRC_SM_OFF, TMRC_SM_R1, TMRC_SM_R2, TMRC_SM_R3,
    TMRC_SM_RESTART, TMRC_SM_PAUSE, TMRC_SM_EVENT, TMRC_SM_EXTCLK
  } tmrc_slave_t;

  typedef enum logic [2:0] {
    TMRC_MM_RESET, TMRC_MM_ENABLE, TMRC_MM_UPDATE, TMRC_MM_CCPULSE,
    TMRC_MM_REF0, TMRC_MM_REF1, TMRC_MM_REF2, TMRC_MM_REF3
  } tmrc_master_t;
endpackage : tmrc_pkg

/* File: design/tmrc_timer_control.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module tmrc_timer_control #(
  parameter int RELOAD_W = 16,
  parameter int DT_CYCLES = tmrc_pkg::TMRC_DT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic internalTrigger0,
  input wire logic internalTrigger1,
  input wire logic ch0EdgeFlag,
  input wire logic ch0FilteredInput,
  input wire logic ch1FilteredInput,
  input wire logic counterOverflow,
  input wire logic ch0Event,
  input wire logic ch1Event,
  input wire logic [3:0] compareReference,
  input wire logic primaryOutputEnable,
  input wire logic breakEvent,
  input wire logic ch0ActiveLevel,
  input wire logic ch0ComplActiveLevel,
  output logic triggerOutput,
  output logic counterAdvance,
  output logic counterReinit,
  output logic updateEvent,
  output logic [RELOAD_W-1:0] reloadValue,
  output logic commutationEvent,
  output logic [1:0] ch0Output,
  output logic ch0ComplOutput,
  output logic ch1IdleLevel,
  output logic [4:0] dmaRequest,
  output logic [5:0] irqRequest
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [6:0] pinMeta;
  logic [6:0] pinSync;
  logic [6:0] pinRaw;
  assign pinRaw = {primaryOutputEnable, ch1FilteredInput, ch0FilteredInput, ch0EdgeFlag,
    internalTrigger1, internalTrigger0, breakEvent};
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinMeta <= 7'h00;
      pinSync <= 7'h00;
    end
    else
    begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end
  wire outEnSync = pinSync[6];
  wire breakSync = pinSync[0];

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrlReg;
  logic [15:0] outReg;
  logic [15:0] slaveReg;
  logic [15:0] enReg;
  logic [15:0] flagReg;
  logic [RELOAD_W-1:0] reloadPre;
  logic [1:0] lockLevel;
  logic [15:0] swevPulse;
  logic [1:0] cmtPre;
  logic [1:0] cmtAct;

  wire wrCtrl = regWrite && regAddr == tmrc_pkg::TMRC_OFS_CTRL;
  wire wrOut = regWrite && regAddr == tmrc_pkg::TMRC_OFS_OUT;
  wire wrSlave = regWrite && regAddr == tmrc_pkg::TMRC_OFS_SLAVE;
  wire wrEn = regWrite && regAddr == tmrc_pkg::TMRC_OFS_EN;
  wire wrFlags = regWrite && regAddr == tmrc_pkg::TMRC_OFS_FLAGS;
  wire wrSwev = regWrite && regAddr == tmrc_pkg::TMRC_OFS_SWEV;
  wire wrReload = regWrite && regAddr == tmrc_pkg::TMRC_OFS_RELOAD;
  wire wrProt = regWrite && regAddr == tmrc_pkg::TMRC_OFS_LOCK_LEVEL;

  wire reloadBuffered = ctrlReg[tmrc_pkg::TMRC_B_ARB];
  wire oneShot = ctrlReg[tmrc_pkg::TMRC_B_ONE];
  wire updSource = ctrlReg[tmrc_pkg::TMRC_B_UPS];
  wire updInhibit = ctrlReg[tmrc_pkg::TMRC_B_INH];
  wire runBit = ctrlReg[tmrc_pkg::TMRC_B_RUN];
  wire [2:0] masterSel = outReg[tmrc_pkg::TMRC_B_MMLO +: 3];
  wire [2:0] slaveSel = slaveReg[tmrc_pkg::TMRC_B_SMLO +: 3];
  wire [2:0] trigSel = slaveReg[tmrc_pkg::TMRC_B_TSLO +: 3];
  wire msSync = slaveReg[tmrc_pkg::TMRC_B_MSM];
  wire swUpdate = swevPulse[tmrc_pkg::TMRC_F_UP];
  wire swCmt = swevPulse[tmrc_pkg::TMRC_F_CMT];

  // ****************************************
  // trigger selection and slave controller
  // ****************************************
  logic trigIn;
  always_comb
  begin
    case (trigSel)
      3'h0: trigIn = pinSync[1];
      3'h1: trigIn = pinSync[2];
      3'h4: trigIn = pinSync[3];
      3'h5: trigIn = pinSync[4];
      3'h6: trigIn = pinSync[5];
      default: trigIn = 1'b0;
    endcase
  end
  logic trigPrev;
  wire trigRise = trigIn && !trigPrev;
  tmrc_pkg::tmrc_slave_t slaveMode;
  assign slaveMode = tmrc_pkg::tmrc_slave_t'(slaveSel);
  logic pauseOk;
  logic slaveReset;
  logic slaveStart;
  logic extTick;
  always_comb
  begin
    pauseOk = 1'b1;
    slaveReset = 1'b0;
    slaveStart = 1'b0;
    extTick = 1'b0;
    case (slaveMode)
      tmrc_pkg::TMRC_SM_RESTART: slaveReset = trigRise;
      tmrc_pkg::TMRC_SM_PAUSE: pauseOk = trigIn;
      tmrc_pkg::TMRC_SM_EVENT: slaveStart = trigRise;
      tmrc_pkg::TMRC_SM_EXTCLK: extTick = trigRise;
      default: pauseOk = 1'b1;
    endcase
  end
  wire internalEnable = runBit && pauseOk;
  assign counterAdvance = slaveMode == tmrc_pkg::TMRC_SM_EXTCLK ?
    (runBit && extTick) : internalEnable;
  wire trigEvent = (slaveMode == tmrc_pkg::TMRC_SM_PAUSE ? trigIn != trigPrev : trigRise)
    && slaveMode != tmrc_pkg::TMRC_SM_OFF;

  // ****************************************
  // update event generation
  // ****************************************
  // inhibit blocks the update itself, not the reinitialisation
  wire updRaw = swUpdate || counterOverflow || slaveReset;
  assign updateEvent = updRaw && !updInhibit;
  assign counterReinit = swUpdate || slaveReset;
  wire updFlagSet = updateEvent && (!updSource || counterOverflow);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reloadValue <= '0;
    else if (!reloadBuffered && wrReload)
      reloadValue <= regWdata[RELOAD_W-1:0];
    else if (reloadBuffered && updateEvent)
      reloadValue <= reloadPre;
  end

  // ****************************************
  // commutation shadow
  // ****************************************
  wire cmtBuffered = outReg[tmrc_pkg::TMRC_B_COMMUTATION_BUFFERING];
  assign commutationEvent = swCmt || (outReg[tmrc_pkg::TMRC_B_COMMUTATION_UPDATE_CONTROL] && trigRise);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cmtAct <= 2'h3;
    else if (!cmtBuffered || commutationEvent)
      cmtAct <= cmtPre;
  end

  // ****************************************
  // master trigger output
  // ****************************************
  logic resetPulseDly;
  logic trigOutNext;
  always_comb
  begin
    case (tmrc_pkg::tmrc_master_t'(masterSel))
      tmrc_pkg::TMRC_MM_RESET: trigOutNext = swUpdate || resetPulseDly;
      tmrc_pkg::TMRC_MM_ENABLE: trigOutNext = internalEnable;
      tmrc_pkg::TMRC_MM_UPDATE: trigOutNext = updateEvent;
      tmrc_pkg::TMRC_MM_CCPULSE: trigOutNext = ch0Event;
      default: trigOutNext = compareReference[masterSel[1:0]];
    endcase
  end
  // sync mode sends the start straight through so slaves start together
  assign triggerOutput = msSync ? trigRise : trigOutNext;

  // ****************************************
  // idle outputs with dead-time on main output
  // ****************************************
  logic [3:0] deadCnt;
  wire [3:0] deadLoad = 4'(DT_CYCLES);
  wire idleMain = outReg[tmrc_pkg::TMRC_B_CH0_IDLE_LEVEL];
  wire idleCompl = outReg[tmrc_pkg::TMRC_B_CH0_COMPL_IDLE_LEVEL];
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      deadCnt <= 4'h0;
    else if (outEnSync)
      deadCnt <= deadLoad;
    else if (deadCnt != 4'h0)
      deadCnt <= deadCnt - 4'h1;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ch0Output <= 2'h0;
      ch0ComplOutput <= 1'b0;
    end
    else
    begin
      ch0Output[0] <= outEnSync ? ch0ActiveLevel && cmtAct[0] :
        (deadCnt == 4'h0 ? idleMain : 1'b0);
      ch0Output[1] <= outEnSync && cmtAct[0];
      ch0ComplOutput <= outEnSync ? ch0ComplActiveLevel && cmtAct[1] : idleCompl;
    end
  end
  assign ch1IdleLevel = outReg[tmrc_pkg::TMRC_B_CH1_IDLE_LEVEL];

  // ****************************************
  // register writes and flags
  // ****************************************
  wire [15:0] hwFlags = {8'h00, breakSync || swevPulse[tmrc_pkg::TMRC_F_BRK],
    trigEvent || swevPulse[tmrc_pkg::TMRC_F_TRG], commutationEvent, 2'h0,
    ch1Event || swevPulse[tmrc_pkg::TMRC_F_CH1], ch0Event || swevPulse[tmrc_pkg::TMRC_F_CH0],
    updFlagSet};
  wire [15:0] ovcSet = {5'h00, ch1Event && flagReg[tmrc_pkg::TMRC_F_CH1],
    ch0Event && flagReg[tmrc_pkg::TMRC_F_CH0], 9'h000};
  wire [15:0] flagsKept = wrFlags ? (flagReg & regWdata) : flagReg;
  wire lockOpen = lockLevel == tmrc_pkg::TMRC_LOCK_OPEN;
  wire [15:0] isoMask = lockOpen ? tmrc_pkg::TMRC_ISO_MASK : 16'h0000;
  wire [15:0] outWrMask = tmrc_pkg::TMRC_OUT_MASK | isoMask;
  wire clearRun = oneShot && updateEvent && !wrCtrl;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlReg <= tmrc_pkg::TMRC_RST;
      outReg <= tmrc_pkg::TMRC_RST;
      slaveReg <= tmrc_pkg::TMRC_RST;
      enReg <= tmrc_pkg::TMRC_RST;
      flagReg <= tmrc_pkg::TMRC_RST;
      reloadPre <= '0;
      lockLevel <= 2'h0;
      swevPulse <= 16'h0000;
      cmtPre <= 2'h3;
      trigPrev <= 1'b0;
      resetPulseDly <= 1'b0;
    end
    else
    begin
      trigPrev <= trigIn;
      resetPulseDly <= slaveReset;
      swevPulse <= wrSwev ? regWdata : 16'h0000;
      if (wrCtrl)
        ctrlReg <= regWdata & tmrc_pkg::TMRC_CTRL_MASK;
      else if (clearRun)
        ctrlReg[tmrc_pkg::TMRC_B_RUN] <= 1'b0;
      else if (slaveStart || (msSync && trigRise && slaveMode == tmrc_pkg::TMRC_SM_EVENT))
        ctrlReg[tmrc_pkg::TMRC_B_RUN] <= 1'b1;
      if (wrOut)
        outReg <= (regWdata & outWrMask) | (outReg & ~outWrMask);
      if (wrSlave)
        slaveReg <= regWdata & tmrc_pkg::TMRC_SLV_MASK;
      if (wrEn)
        enReg <= regWdata & tmrc_pkg::TMRC_EN_MASK;
      if (wrReload)
        reloadPre <= regWdata[RELOAD_W-1:0];
      if (wrProt)
        lockLevel <= regWdata[1:0];
      if (wrProt)
        cmtPre <= regWdata[5:4];
      // set wins over clear
      flagReg <= (flagsKept | ((hwFlags | ovcSet) & tmrc_pkg::TMRC_FLAG_MASK));
    end
  end

  // ****************************************
  // requests
  // ****************************************
  wire dmaSrcUpd = outReg[tmrc_pkg::TMRC_B_DMA_SOURCE_SELECT];
  wire ch0DmaEv = dmaSrcUpd ? updFlagSet : hwFlags[tmrc_pkg::TMRC_F_CH0];
  wire ch1DmaEv = dmaSrcUpd ? updFlagSet : hwFlags[tmrc_pkg::TMRC_F_CH1];
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dmaRequest <= 5'h00;
      irqRequest <= 6'h00;
    end
    else
    begin
      dmaRequest <= {hwFlags[tmrc_pkg::TMRC_F_TRG] && enReg[tmrc_pkg::TMRC_B_TRIGGER_DMA_ENABLE],
        hwFlags[tmrc_pkg::TMRC_F_CMT] && enReg[tmrc_pkg::TMRC_B_COMMUTATION_DMA_ENABLE],
        ch1DmaEv && enReg[tmrc_pkg::TMRC_B_CH1_DMA_ENABLE],
        ch0DmaEv && enReg[tmrc_pkg::TMRC_B_CH0_DMA_ENABLE],
        updFlagSet && enReg[tmrc_pkg::TMRC_B_UPDATE_DMA_ENABLE]};
      irqRequest <= {flagReg[tmrc_pkg::TMRC_F_BRK] && enReg[tmrc_pkg::TMRC_B_BREAK_IRQ_ENABLE],
        flagReg[tmrc_pkg::TMRC_F_TRG] && enReg[tmrc_pkg::TMRC_B_TRIGGER_IRQ_ENABLE],
        flagReg[tmrc_pkg::TMRC_F_CMT] && enReg[tmrc_pkg::TMRC_B_COMMUTATION_IRQ_ENABLE],
        flagReg[tmrc_pkg::TMRC_F_CH1] && enReg[tmrc_pkg::TMRC_B_CH1_IRQ_ENABLE],
        flagReg[tmrc_pkg::TMRC_F_CH0] && enReg[tmrc_pkg::TMRC_B_CH0_IRQ_ENABLE],
        flagReg[tmrc_pkg::TMRC_F_UP] && enReg[tmrc_pkg::TMRC_B_UPDATE_IRQ_ENABLE]};
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] rdMux;
  always_comb
  begin
    case (regAddr)
      tmrc_pkg::TMRC_OFS_CTRL: rdMux = ctrlReg;
      tmrc_pkg::TMRC_OFS_OUT: rdMux = outReg;
      tmrc_pkg::TMRC_OFS_SLAVE: rdMux = slaveReg;
      tmrc_pkg::TMRC_OFS_EN: rdMux = enReg;
      tmrc_pkg::TMRC_OFS_FLAGS: rdMux = flagReg;
      tmrc_pkg::TMRC_OFS_RELOAD: rdMux = 16'(reloadValue);
      tmrc_pkg::TMRC_OFS_LOCK_LEVEL: rdMux = {10'h000, cmtAct, 2'h0, lockLevel};
      default: rdMux = 16'h0000;
    endcase
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 16'h0000;
    else
      regRdata <= regRead ? rdMux : 16'h0000;
  end

  // ****************************************
  // checks
  // ****************************************
  one_shot_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    oneShot && updateEvent && !wrCtrl |=> !runBit)
    else $error("one-shot did not clear run bit");
  upd_inhibit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    updInhibit |-> !updateEvent)
    else $error("update event while inhibited");
  ups_filter_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    updFlagSet && updSource |-> counterOverflow)
    else $error("update flag from wrong source");
  idle_compl_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !outEnSync |=> ch0ComplOutput == $past(idleCompl))
    else $error("complementary idle level wrong");
  idle_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrOut && !lockOpen |=> $stable(outReg[10:8]))
    else $error("idle bits changed while locked");
  mm_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    masterSel == 3'h0 && !msSync && slaveReset ##1 masterSel == 3'h0 && !msSync
    |-> triggerOutput)
    else $error("delayed reset pulse missing");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irqRequest[0] |-> $past(enReg[0]))
    else $error("update interrupt without enable");
  event_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slaveStart && !wrCtrl && !clearRun |=> runBit)
    else $error("event mode did not start counter");
endmodule : tmrc_timer_control

/* File: dv/tmrc_peer_model.sv */
`timescale 1ns/1ps
module tmrc_peer_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic triggerOutput,
  output logic internalTrigger0,
  output logic internalTrigger1,
  output int riseCount
);
  logic lastTrig;
  initial
  begin
    internalTrigger0 = 1'b0;
    internalTrigger1 = 1'b0;
  end
  // caller schedules this just after an edge; the level holds until the next call
  task automatic drive(input int idx, input logic lvl);
    if (idx == 0)
      internalTrigger0 <= lvl;
    else
      internalTrigger1 <= lvl;
  endtask : drive
  // a slave peer takes each low-to-high step of our trigger as one start event
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lastTrig <= 1'b0;
      riseCount <= 0;
    end
    else
    begin
      lastTrig <= triggerOutput;
      if (triggerOutput === 1'b1 && lastTrig === 1'b0)
        riseCount <= riseCount + 1;
    end
  end
endmodule : tmrc_peer_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic ch0FilteredInput = 1'b0;
  logic ch1FilteredInput = 1'b0;
  logic counterOverflow = 1'b0;
  logic ch0Event = 1'b0;
  logic [3:0] compareReference = 4'h0;
  logic primaryOutputEnable = 1'b1;
  // not exercised here: break, edge flag, channel 1 events, active levels
  logic breakEvent = 1'b0;
  logic ch0EdgeFlag = 1'b0;
  logic ch1Event = 1'b0;
  logic ch0ActiveLevel = 1'b0;
  logic ch0ComplActiveLevel = 1'b0;
  logic [15:0] regRdata;
  logic internalTrigger0, internalTrigger1, triggerOutput, counterAdvance, counterReinit;
  logic updateEvent, commutationEvent, ch0ComplOutput, ch1IdleLevel;
  logic [15:0] reloadValue;
  logic [1:0] ch0Output;
  logic [4:0] dmaRequest;
  logic [5:0] irqRequest;
  int riseCount;
  int nUpd = 0;
  int nReinit = 0;
  int nDma0 = 0;
  int nDma1 = 0;
  int nAdv = 0;
  int mismatches = 0;
  int checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  tmrc_timer_control dut (.*);
  tmrc_peer_model peer (.sys_clk(sys_clk), .reset_n(reset_n), .triggerOutput(triggerOutput),
    .internalTrigger0(internalTrigger0), .internalTrigger1(internalTrigger1),
    .riseCount(riseCount));

  always @(posedge sys_clk)
  begin
    nUpd <= nUpd + (updateEvent === 1'b1);
    nReinit <= nReinit + (counterReinit === 1'b1);
    nDma0 <= nDma0 + (dmaRequest[0] === 1'b1);
    nDma1 <= nDma1 + (dmaRequest[1] === 1'b1);
    nAdv <= nAdv + (counterAdvance === 1'b1);
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // ends 1 ns past the edge so combinational outputs are settled
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [15:0] e, input string m);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e, m);
  endtask : rc
  task automatic pulse(input int k);
    @(posedge sys_clk);
    if (k == 0)
      counterOverflow <= 1'b1;
    else
      ch0Event <= 1'b1;
    @(posedge sys_clk);
    counterOverflow <= 1'b0;
    ch0Event <= 1'b0;
    idle(3);
  endtask : pulse
  task automatic swupd;
    wr(5'h14, 16'h0001);
    idle(3);
  endtask : swupd
  // inputs pass a two-stage synchroniser, so five cycles cover the latency
  task automatic src(input int k, input logic v);
    @(posedge sys_clk);
    case (k)
      0: peer.drive(0, v);
      1: peer.drive(1, v);
      2: ch0FilteredInput <= v;
      default: ch1FilteredInput <= v;
    endcase
    idle(5);
  endtask : src

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [4:0] a [3] = '{5'h00, 5'h08, 5'h0C};
    logic [15:0] m [3] = '{16'h008F, 16'h00F7, 16'h67E7};
    rc(5'h1E, 16'h0000, "unmapped");
    rc(5'h10, 16'h0000, "flags reset");
    rc(5'h04, 16'h0000, "out reset");
    for (int i = 0; i < 3; i++)
    begin
      rc(a[i], 16'h0000, "reset value");
      wr(a[i], 16'hFFFF);
      rc(a[i], m[i], "rw mask");
      wr(a[i], 16'h0000);
    end
    wr(5'h04, 16'hFFFF);
    rc(5'h04, 16'h077D, "out mask");
    wr(5'h1C, 16'h0001);
    wr(5'h04, 16'h0000);
    rc(5'h04, 16'h0700, "idle bits locked");
    wr(5'h1C, 16'h0000);
    wr(5'h04, 16'h0000);
    rc(5'h04, 16'h0000, "idle bits open");
    $display("test regs done");
  endtask : t_regs

  task automatic t_upd;
    int u, r, t, d;
    wr(5'h0C, 16'h0101);
    u = nUpd;
    r = nReinit;
    t = riseCount;
    d = nDma0;
    swupd;
    chk(16'(nUpd - u), 16'h0001, "sw update");
    chk(16'(riseCount - t), 16'h0001, "reset mode pulse");
    chk(16'(nDma0 - d), 16'h0001, "update dma");
    rc(5'h10, 16'h0001, "update flag");
    chk({10'h000, irqRequest}, 16'h0001, "update irq");
    wr(5'h0C, 16'h0000);
    idle(2);
    chk({10'h000, irqRequest}, 16'h0000, "irq masked");
    d = nDma0;
    swupd;
    chk(16'(nDma0 - d), 16'h0000, "dma masked");
    wr(5'h10, 16'h0000);
    wr(5'h00, 16'h0004);
    swupd;
    rc(5'h10, 16'h0000, "sw update filtered");
    pulse(0);
    rc(5'h10, 16'h0001, "overflow flag");
    wr(5'h10, 16'h0000);
    wr(5'h00, 16'h0002);
    u = nUpd;
    r = nReinit;
    swupd;
    chk(16'(nUpd - u), 16'h0000, "inhibited update");
    chk(16'(nReinit - r), 16'h0001, "inhibited reinit");
    wr(5'h00, 16'h0000);
    wr(5'h0C, 16'h0200);
    d = nDma1;
    pulse(1);
    chk(16'(nDma1 - d), 16'h0001, "ch0 dma on event");
    wr(5'h04, 16'h0008);
    pulse(1);
    swupd;
    chk(16'(nDma1 - d), 16'h0002, "ch0 dma on update");
    wr(5'h04, 16'h0000);
    wr(5'h0C, 16'h0000);
    wr(5'h10, 16'h0000);
    $display("test update done");
  endtask : t_upd

  task automatic t_master;
    int t;
    wr(5'h04, 16'h0010);
    wr(5'h00, 16'h0001);
    idle(1);
    chk({15'h0000, triggerOutput}, 16'h0001, "enable mode on");
    wr(5'h00, 16'h0000);
    idle(1);
    chk({15'h0000, triggerOutput}, 16'h0000, "enable mode off");
    wr(5'h04, 16'h0020);
    t = riseCount;
    swupd;
    chk(16'(riseCount - t), 16'h0001, "update mode");
    wr(5'h04, 16'h0030);
    pulse(1);
    chk(16'(riseCount - t), 16'h0002, "match mode");
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h04, 16'(64 + 16 * i));
      for (int j = 0; j < 4; j++)
      begin
        @(posedge sys_clk);
        compareReference <= 4'(1 << j);
        idle(1);
        chk({15'h0000, triggerOutput}, 16'(i == j), "reference select");
      end
    end
    @(posedge sys_clk);
    compareReference <= 4'h0;
    wr(5'h04, 16'h0000);
    wr(5'h10, 16'h0000);
    $display("test master done");
  endtask : t_master

  task automatic t_slave;
    // pause mode never pairs with the edge flag source
    logic [15:0] code [4] = '{16'h0005, 16'h0015, 16'h0055, 16'h0065};
    int r, t;
    wr(5'h00, 16'h0001);
    idle(1);
    chk({15'h0000, counterAdvance}, 16'h0001, "free run");
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h08, code[k]);
      src(k, 1'b1);
      chk({15'h0000, counterAdvance}, 16'h0001, "pause high");
      src(k, 1'b0);
      chk({15'h0000, counterAdvance}, 16'h0000, "pause low");
    end
    wr(5'h08, 16'h0007);
    r = nAdv;
    src(0, 1'b1);
    src(0, 1'b0);
    chk(16'(nAdv - r), 16'h0001, "external clock");
    wr(5'h08, 16'h0000);
    wr(5'h00, 16'h0000);
    idle(1);
    chk({15'h0000, counterAdvance}, 16'h0000, "stopped");
    wr(5'h08, 16'h0004);
    r = nReinit;
    t = riseCount;
    src(0, 1'b1);
    chk(16'(nReinit - r), 16'h0001, "restart");
    chk(16'(riseCount - t), 16'h0001, "slave reset pulse");
    src(0, 1'b0);
    wr(5'h08, 16'h0086);
    t = riseCount;
    src(0, 1'b1);
    rc(5'h00, 16'h0001, "event start");
    chk(16'(riseCount != t), 16'h0001, "sync passthrough");
    src(0, 1'b0);
    rc(5'h00, 16'h0001, "never stopped");
    wr(5'h08, 16'h0000);
    wr(5'h00, 16'h0000);
    $display("test slave done");
  endtask : t_slave

  task automatic t_misc;
    wr(5'h00, 16'h0009);
    pulse(0);
    rc(5'h00, 16'h0008, "one shot stops");
    wr(5'h00, 16'h0001);
    pulse(0);
    rc(5'h00, 16'h0001, "repeat continues");
    wr(5'h00, 16'h0000);
    wr(5'h18, 16'h1234);
    rc(5'h18, 16'h1234, "direct reload");
    wr(5'h00, 16'h0080);
    wr(5'h18, 16'h5678);
    rc(5'h18, 16'h1234, "reload held");
    swupd;
    rc(5'h18, 16'h5678, "reload on update");
    wr(5'h00, 16'h0000);
    wr(5'h04, 16'h0001);
    wr(5'h1C, 16'h0030);
    rc(5'h1C, 16'h0000, "cmt held");
    wr(5'h14, 16'h0020);
    rc(5'h1C, 16'h0030, "cmt on request");
    wr(5'h04, 16'h0005);
    wr(5'h1C, 16'h0000);
    src(0, 1'b1);
    rc(5'h1C, 16'h0000, "cmt on trigger");
    src(0, 1'b0);
    wr(5'h04, 16'h0700);
    @(posedge sys_clk);
    primaryOutputEnable <= 1'b0;
    idle(4);
    chk({12'h000, ch1IdleLevel, ch0ComplOutput, ch0Output}, 16'h000C, "dead-time");
    idle(8);
    chk({13'h0000, ch1IdleLevel, ch0ComplOutput, ch0Output[0]}, 16'h0007, "idle high");
    wr(5'h04, 16'h0000);
    idle(12);
    chk({13'h0000, ch1IdleLevel, ch0ComplOutput, ch0Output[0]}, 16'h0000, "idle low");
    @(posedge sys_clk);
    primaryOutputEnable <= 1'b1;
    $display("test misc done");
  endtask : t_misc

  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs;
    t_upd;
    t_master;
    t_slave;
    t_misc;
    end_sim;
  end

  // tests need about 400 cycles; allow twenty-five times that
  initial
  begin
    #50000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    end_sim;
  end
endmodule : tb
